// ### core/revc_pkg.sv
// constants and types of the regulator enable and voltage control register bank
// Notes on behaviour
// - enable-source field bits 2:1: 00 sequencer, 01/10/11 input pin one/two/three
// - chosen pin going active turns regulator on, going passive turns it off
// - chosen voltage pin going active picks setting B, going passive picks A
// - voltage-source field bits 6:5: 00 sequencer, 01/10/11 input pin one/two/three
// - control bit 0 requests off (0) or on (1), subject to source priority
// - control bit 3: 0 pull-down connected while off, 1 disconnected
// - control bit 7: default supply, or sequenced and kept on in low power off
// - select bits 7..4 pick A (0) or B (1) for regulators four..one
// - select bits 3,2,0 pick A/B for converters two, three, one; bit 1 reserved
// - control bit 4 is reserved and controls nothing
package revc_pkg;

  localparam int unsigned NUM_REG  = 4;
  localparam int unsigned NUM_CONV = 3;
  localparam int unsigned NUM_PIN  = 3;

  // printed register indices; byte address is four times the index
  localparam logic [11:0] IDX_CTRL1 = 12'h026;
  localparam logic [11:0] IDX_CTRL2 = 12'h027;
  localparam logic [11:0] IDX_CTRL3 = 12'h028;
  localparam logic [11:0] IDX_CTRL4 = 12'h029;
  localparam logic [11:0] IDX_VSEL  = 12'h032;
  localparam int unsigned ADDR_LSB  = 2;

  // control register field positions
  localparam int unsigned CTL_ON_BIT   = 0;
  localparam int unsigned CTL_ENSRC_LO = 1;
  localparam int unsigned CTL_PDDIS    = 3;
  localparam int unsigned CTL_VSRC_LO  = 5;
  localparam int unsigned CTL_CONF     = 7;

  // select register field positions
  localparam int unsigned VS_REG_LO = 4;
  localparam int unsigned VS_CONV1  = 0;
  localparam int unsigned VS_CONV3  = 2;
  localparam int unsigned VS_CONV2  = 3;

  // writable bits; the rest are reserved and read zero
  localparam logic [7:0] CTRL_MASK = 8'hEF;
  localparam logic [7:0] VSEL_MASK = 8'hFD;

  // values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] VSEL_RESET = 8'h00;

  // source selector encoding
  typedef enum logic [1:0] {
    REVC_SRC_SEQ  = 2'h0,
    REVC_SRC_PIN1 = 2'h1,
    REVC_SRC_PIN2 = 2'h2,
    REVC_SRC_PIN3 = 2'h3
  } revc_src_t;

  // bus phase state, gray along idle -> read wait
  typedef enum logic [0:0] {
    REVC_BUS_IDLE  = 1'h0,
    REVC_BUS_RDWAIT = 1'h1
  } revc_bus_t;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// ### core/revc_edge.sv
// level synchroniser and edge detector for a group of event inputs
`timescale 1ns/1ps

module revc_edge #(
  parameter int unsigned W      = 3,
  parameter bit          SYNC   = 1'b1,
  parameter logic [W-1:0] ACTIVE = '1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  // raw inputs
  input  wire logic [W-1:0] raw_i,
  // passive-to-active and active-to-passive pulses
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] stab_r;
  logic [W-1:0] prev_r;
  wire  [W-1:0] lvl = ~(raw_i ^ ACTIVE);

  // first stage feeds only the second; bypassed for same-clock sources
  generate
    if (SYNC) begin : g_sync
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          meta_r <= '0;
          stab_r <= '0;
        end else begin
          meta_r <= lvl;
          stab_r <= meta_r;
        end
      end
    end else begin : g_nosync
      assign meta_r = '0;
      assign stab_r = lvl;
    end
  endgenerate

  // previous level; starts passive so an input active at reset gives one rise
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_r <= '0;
    end else begin
      prev_r <= stab_r;
    end
  end

  assign rise_o = stab_r & ~prev_r;
  assign fall_o = ~stab_r & prev_r;

endmodule

// ### core/revc_top.sv
// regulator enable and voltage select register bank with AHB-Lite slave
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps

module revc_top
  import revc_pkg::*;
#(
  parameter logic [revc_pkg::NUM_PIN-1:0] PIN_ACTIVE = 3'h7
) (
  // clock and reset
  input  wire logic                            REF_CLK_I,
  input  wire logic                            RSTN_I,
  // AHB-Lite slave
  input  wire logic                            HSEL_I,
  input  wire logic [31:0]                     HADDR_I,
  input  wire logic [1:0]                      HTRANS_I,
  input  wire logic                            HWRITE_I,
  input  wire logic [2:0]                      HSIZE_I,
  input  wire logic [31:0]                     HWDATA_I,
  input  wire logic                            HREADY_I,
  output logic      [31:0]                     HRDATA_O,
  output logic                                 HREADYOUT_O,
  output logic                                 HRESP_O,
  // input pins one..three, asynchronous
  input  wire logic [revc_pkg::NUM_PIN-1:0]    INPUT_PIN_I,
  // power sequencer, same clock
  input  wire logic [revc_pkg::NUM_REG-1:0]    SEQ_REG_ON_I,
  input  wire logic [revc_pkg::NUM_REG-1:0]    SEQ_REG_VSEL_I,
  input  wire logic                            LOW_POWER_OFF_I,
  // regulator controls
  output logic      [revc_pkg::NUM_REG-1:0]    REG_ON_O,
  output logic      [revc_pkg::NUM_REG-1:0]    REG_PULLDOWN_O,
  output logic      [revc_pkg::NUM_REG-1:0]    REG_VOLTAGE_CHOICE_O,
  output logic      [revc_pkg::NUM_REG-1:0]    REG_SEQ_HANDLED_O,
  output logic      [revc_pkg::NUM_CONV-1:0]   CONV_VOLTAGE_CHOICE_O
);

  import revc_pkg::*;

  // register state
  // four control bytes and one select byte; reserved bits are never stored,
  // so the masks at the write port are the only place that keeps them zero
  // bus_r tracks the read wait state; wr_pend_r marks a write data phase
  // addr_r holds the captured word index for the whole data phase
  logic [7:0]           ctrl_r   [NUM_REG];
  logic [7:0]           ctrl_nxt [NUM_REG];
  logic [7:0]           vsel_r;
  logic [7:0]           vsel_nxt;
  revc_bus_t            bus_r;
  logic                 wr_pend_r;
  logic [11:0]          addr_r;

  // pin and sequencer edges
  logic [NUM_PIN-1:0]   pin_rise;
  logic [NUM_PIN-1:0]   pin_fall;
  logic [NUM_REG-1:0]   seq_on_rise;
  logic [NUM_REG-1:0]   seq_on_fall;
  logic [NUM_REG-1:0]   seq_vs_rise;
  logic [NUM_REG-1:0]   seq_vs_fall;

  // external pins cross into this clock through two flops
  // the pin path adds three edges of delay before the register bit moves;
  // a pulse shorter than a clock period may be missed
  revc_edge #(
    .W      (NUM_PIN),
    .SYNC   (1'b1),
    .ACTIVE (PIN_ACTIVE)
  ) u_pin_edge (
    .clk_i  (REF_CLK_I),
    .rstn_i (RSTN_I),
    .raw_i  (INPUT_PIN_I),
    .rise_o (pin_rise),
    .fall_o (pin_fall)
  );

  // sequencer requests are on our clock: edges only, no sync
  // skipping the flops saves two cycles of reaction time
  revc_edge #(
    .W      (NUM_REG),
    .SYNC   (1'b0),
    .ACTIVE ('1)
  ) u_seq_on_edge (
    .clk_i  (REF_CLK_I),
    .rstn_i (RSTN_I),
    .raw_i  (SEQ_REG_ON_I),
    .rise_o (seq_on_rise),
    .fall_o (seq_on_fall)
  );

  revc_edge #(
    .W      (NUM_REG),
    .SYNC   (1'b0),
    .ACTIVE ('1)
  ) u_seq_vs_edge (
    .clk_i  (REF_CLK_I),
    .rstn_i (RSTN_I),
    .raw_i  (SEQ_REG_VSEL_I),
    .rise_o (seq_vs_rise),
    .fall_o (seq_vs_fall)
  );

  // picks the event of the selected source; used for both on/off and A/B
  // all four codes are legal, so the case needs no default
  // the sequencer code stands beside the pins so one path serves both
  function automatic logic pick_event(input logic [1:0] src, input logic seq_ev,
                                      input logic [NUM_PIN-1:0] pin_ev);
    logic ev;
    ev = 1'b0;
    unique case (revc_src_t'(src))
      REVC_SRC_SEQ:  ev = seq_ev;
      REVC_SRC_PIN1: ev = pin_ev[0];
      REVC_SRC_PIN2: ev = pin_ev[1];
      REVC_SRC_PIN3: ev = pin_ev[2];
    endcase
    return ev;
  endfunction

  // bus decode
  // a transfer is taken only when the bus is ready and the master
  // asks for NONSEQ or SEQ; IDLE and BUSY are ignored
  // hsize is not checked: every register sits in its own aligned word,
  // and a narrower access simply sees the low byte
  // the index decode runs off the captured address, so the data phase
  // never depends on what the master drives for the next address phase
  wire        xfer_req  = HSEL_I & HREADY_I & (HTRANS_I == HTRANS_NONSEQ || HTRANS_I == HTRANS_SEQ);
  wire [11:0] xfer_idx  = HADDR_I[ADDR_LSB +: 12];
  wire        wr_hit    = wr_pend_r;
  wire        hit_ctrl1 = (addr_r == IDX_CTRL1);
  wire        hit_ctrl2 = (addr_r == IDX_CTRL2);
  wire        hit_ctrl3 = (addr_r == IDX_CTRL3);
  wire        hit_ctrl4 = (addr_r == IDX_CTRL4);
  wire        hit_vsel  = (addr_r == IDX_VSEL);
  wire [3:0]  hit_ctrl  = {hit_ctrl4, hit_ctrl3, hit_ctrl2, hit_ctrl1};

  // read mux; reserved bits were never stored so they read zero
  wire [7:0]  rd_byte   = hit_ctrl1 ? ctrl_r[0] :
                          hit_ctrl2 ? ctrl_r[1] :
                          hit_ctrl3 ? ctrl_r[2] :
                          hit_ctrl4 ? ctrl_r[3] :
                          hit_vsel  ? vsel_r    : 8'h00;

  // address phase capture; reads take one wait state so they see prior writes
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      bus_r       <= REVC_BUS_IDLE;
      wr_pend_r   <= 1'b0;
      addr_r      <= 12'h000;
      HREADYOUT_O <= 1'b1;
      HRDATA_O    <= 32'h0000_0000;
    end else begin
      unique case (bus_r)
        REVC_BUS_IDLE: begin
          wr_pend_r <= xfer_req & HWRITE_I;
          if (xfer_req) begin
            addr_r <= xfer_idx;
          end
          if (xfer_req && !HWRITE_I) begin
            bus_r       <= REVC_BUS_RDWAIT;
            HREADYOUT_O <= 1'b0;
          end
        end
        REVC_BUS_RDWAIT: begin
          bus_r       <= REVC_BUS_IDLE;
          HREADYOUT_O <= 1'b1;
          HRDATA_O    <= {24'h00_0000, rd_byte};
        end
      endcase
    end
  end

  // every transfer, mapped or not, gets an okay answer
  // an error answer would need a two-cycle response; the bank has no
  // failure case worth it, so unmapped words read zero instead
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      HRESP_O <= HRESP_OKAY;
    end else begin
      HRESP_O <= HRESP_OKAY;
    end
  end

  // control registers
  // one byte per regulator: on request, enable source, pull-down disable,
  // voltage source and startup config
  // the on bit has two writers, software and the selected source; the
  // selected source is an edge, so a level held high does not fight software
  // limitation: a source change through a write creates no edge by itself
  // software write first, then hardware edges override: an edge in the write
  // cycle is never lost
  generate
    for (genvar g = 0; g < NUM_REG; g++) begin : g_ctrl
      wire [1:0] en_src = ctrl_r[g][CTL_ENSRC_LO +: 2];
      wire       on_set = pick_event(en_src, seq_on_rise[g], pin_rise);
      wire       on_clr = pick_event(en_src, seq_on_fall[g], pin_fall);

      always_comb begin
        ctrl_nxt[g] = ctrl_r[g];
        if (wr_hit && hit_ctrl[g]) begin
          ctrl_nxt[g] = HWDATA_I[7:0] & CTRL_MASK;
        end
        if (on_set) begin
          ctrl_nxt[g][CTL_ON_BIT] = 1'b1;
        end else if (on_clr) begin
          ctrl_nxt[g][CTL_ON_BIT] = 1'b0;
        end
      end

      always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
          ctrl_r[g] <= CTRL_RESET;
        end else begin
          ctrl_r[g] <= ctrl_nxt[g];
        end
      end
    end
  endgenerate

  // voltage select
  // regulator bits 7..4 have the same two writers as the on bit;
  // converter bits 3, 2 and 0 are written by software alone
  // bit 1 is reserved and masked at the write port
  // the same edge picker serves on/off and A/B, so the two source fields
  // decode identically
  logic [NUM_REG-1:0] vs_set;
  logic [NUM_REG-1:0] vs_clr;

  generate
    for (genvar g = 0; g < NUM_REG; g++) begin : g_vsrc
      wire [1:0] v_src = ctrl_r[g][CTL_VSRC_LO +: 2];
      assign vs_set[g] = pick_event(v_src, seq_vs_rise[g], pin_rise);
      assign vs_clr[g] = pick_event(v_src, seq_vs_fall[g], pin_fall);
    end
  endgenerate

  // regulator bits follow source edges; converter bits are software only
  always_comb begin
    vsel_nxt = vsel_r;
    if (wr_hit && hit_vsel) begin
      vsel_nxt = HWDATA_I[7:0] & VSEL_MASK;
    end
    for (int i = 0; i < NUM_REG; i++) begin
      if (vs_set[i]) begin
        vsel_nxt[VS_REG_LO + i] = 1'b1;
      end else if (vs_clr[i]) begin
        vsel_nxt[VS_REG_LO + i] = 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      vsel_r <= VSEL_RESET;
    end else begin
      vsel_r <= vsel_nxt;
    end
  end

  // outputs
  // every pin of the bank leaves from a flop, which costs one cycle of
  // latency behind the registers but keeps glitches off the regulators
  // pull-down is only ever connected while the regulator is off, so the
  // output stage never loads a running supply
  // low power off masks the on outputs; the stored on bits are untouched,
  // so leaving the state restores the previous regulator set
  // low power off state keeps only regulators marked as sequenced-and-on
  logic [NUM_REG-1:0] on_now;
  logic [NUM_REG-1:0] pd_dis;
  logic [NUM_REG-1:0] conf_bit;

  generate
    for (genvar g = 0; g < NUM_REG; g++) begin : g_out
      assign conf_bit[g] = ctrl_r[g][CTL_CONF];
      assign pd_dis[g]   = ctrl_r[g][CTL_PDDIS];
      assign on_now[g]   = ctrl_r[g][CTL_ON_BIT] & (~LOW_POWER_OFF_I | conf_bit[g]);
    end
  endgenerate

  // registered so every output comes from a flop; one cycle behind the registers
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      REG_ON_O              <= '0;
      REG_PULLDOWN_O        <= '0;
      REG_VOLTAGE_CHOICE_O  <= '0;
      REG_SEQ_HANDLED_O     <= '0;
      CONV_VOLTAGE_CHOICE_O <= '0;
    end else begin
      REG_ON_O              <= on_now;
      REG_PULLDOWN_O        <= ~on_now & ~pd_dis;
      REG_VOLTAGE_CHOICE_O  <= vsel_r[VS_REG_LO +: NUM_REG];
      REG_SEQ_HANDLED_O     <= conf_bit;
      CONV_VOLTAGE_CHOICE_O <= {vsel_r[VS_CONV3], vsel_r[VS_CONV2], vsel_r[VS_CONV1]};
    end
  end

endmodule

// ### sim/revc_top_props.sv
// assertion checker for the regulator control register bank
`timescale 1ns/1ps

module revc_top_props
  import revc_pkg::*;
(
  // clock, reset and bus
  input wire logic        REF_CLK_I,
  input wire logic        RSTN_I,
  input wire logic        HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HWRITE_I,
  input wire logic        HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic        HREADYOUT_O,
  input wire logic        HRESP_O,
  // pins and regulator side
  input wire logic [2:0]  INPUT_PIN_I,
  input wire logic        LOW_POWER_OFF_I,
  input wire logic [3:0]  REG_ON_O,
  input wire logic [3:0]  REG_PULLDOWN_O,
  input wire logic [3:0]  REG_SEQ_HANDLED_O,
  input wire logic [2:0]  CONV_VOLTAGE_CHOICE_O
);
  logic        rd_r;
  logic        wr_r;
  logic [11:0] idx_r;
  wire         tk      = HSEL_I & HREADY_I & HTRANS_I[1];
  wire         rd_done = rd_r & HREADY_I;

  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  // data phase tracker, held while the slave stalls
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rd_r  <= 1'b0;
      wr_r  <= 1'b0;
      idx_r <= 12'h000;
    end else if (HREADY_I) begin
      rd_r  <= tk & ~HWRITE_I;
      wr_r  <= tk & HWRITE_I;
      idx_r <= HADDR_I[13:2];
    end
  end

  okay_resp_a: assert property (HRESP_O == HRESP_OKAY)
    else $error("slave response not okay");
  short_stall_a: assert property (!HREADYOUT_O |=> HREADYOUT_O)
    else $error("read stall longer than one cycle");
  rdata_high_a: assert property (rd_done |-> HRDATA_O[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  ctrl_rsvd_a: assert property (rd_done && idx_r >= IDX_CTRL1 && idx_r <= IDX_CTRL4 |-> !HRDATA_O[4])
    else $error("control reserved bit reads one");
  vsel_rsvd_a: assert property (rd_done && idx_r == IDX_VSEL |-> !HRDATA_O[1])
    else $error("select reserved bit reads one");
  pulldown_off_a: assert property ((REG_ON_O & REG_PULLDOWN_O) == 4'h0)
    else $error("pull-down connected while regulator on");
  handled_write_a: assert property ($changed(REG_SEQ_HANDLED_O) |-> $past(wr_r, 2) || $past(wr_r, 3))
    else $error("startup config changed without a write");
  conv_write_a: assert property ($changed(CONV_VOLTAGE_CHOICE_O) |-> $past(wr_r, 2) || $past(wr_r, 3))
    else $error("converter choice changed without a write");
  low_power_a: assert property (LOW_POWER_OFF_I [*3] |-> (REG_ON_O & ~REG_SEQ_HANDLED_O) == 4'h0)
    else $error("unsequenced regulator on in low power off");

  // main scenarios reached
  cover property (rd_done);
  cover property ($rose(INPUT_PIN_I[0]));
  cover property (LOW_POWER_OFF_I && REG_SEQ_HANDLED_O != 4'h0);
endmodule

bind revc_top revc_top_props u_props (.*);

// ### sim/revc_pin_model.sv
// system logic model driving the three input pins
`timescale 1ns/1ps

module revc_pin_model (
  // commanded level and pace
  input  wire logic [2:0] lvl_i,
  input  wire logic       slow_i,
  // pins toward the device
  output logic      [2:0] pin_o
);
  initial pin_o = 3'h0;
  // pins are asynchronous to the device clock, so skew lands off the edges
  always @(lvl_i) begin
    pin_o <= #(slow_i ? 40 : 7) lvl_i;
  end
endmodule

// ### sim/regulator_enable_voltage_ctrl_tb.sv
// self-checking bench for the regulator control register bank
`timescale 1ns/1ps

module regulator_enable_voltage_ctrl_tb;
  import revc_pkg::*;
  logic        REF_CLK_I, RSTN_I, HSEL_I, HWRITE_I, LOW_POWER_OFF_I, HREADYOUT_O, HRESP_O, slow;
  logic [31:0] HADDR_I, HWDATA_I, HRDATA_O, lfsr_s, rd;
  logic [1:0]  HTRANS_I;
  logic [2:0]  HSIZE_I, INPUT_PIN_I, pin_lvl, CONV_VOLTAGE_CHOICE_O;
  logic [3:0]  SEQ_REG_ON_I, SEQ_REG_VSEL_I, REG_ON_O, REG_PULLDOWN_O, REG_VOLTAGE_CHOICE_O, REG_SEQ_HANDLED_O;
  logic [7:0]  ctl [4];
  logic [7:0]  vs;
  wire         HREADY_I = HREADYOUT_O;
  int          failures, n_tests;
  logic [11:0] idx [5] = '{IDX_CTRL1, IDX_CTRL2, IDX_CTRL3, IDX_CTRL4, IDX_VSEL};

  revc_top uut (.*);
  revc_pin_model u_pins (.lvl_i(pin_lvl), .slow_i(slow), .pin_o(INPUT_PIN_I));

  initial begin
    REF_CLK_I = 1'b0;
    forever #12.5 REF_CLK_I = ~REF_CLK_I;
  end

  function automatic logic [7:0] rnd();
    repeat (8) lfsr_s = {lfsr_s[30:0], lfsr_s[31] ^ lfsr_s[21] ^ lfsr_s[1] ^ lfsr_s[0]};
    return lfsr_s[7:0];
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // one single transfer; a wait that never ends is cut by the count
  task automatic bus(input logic wr, input logic [11:0] ix, input logic [7:0] wd);
    int n;
    n = 0;
    HSEL_I   <= 1'b1;
    HTRANS_I <= HTRANS_NONSEQ;
    HWRITE_I <= wr;
    HADDR_I  <= {18'h0, ix, 2'h0};
    do begin @(posedge REF_CLK_I); n++; end while (HREADY_I !== 1'b1 && n < 40);
    HSEL_I   <= 1'b0;
    HTRANS_I <= 2'h0;
    HWDATA_I <= {24'h0, wd};
    do begin @(posedge REF_CLK_I); n++; end while (HREADY_I !== 1'b1 && n < 40);
    rd = HRDATA_O;
    if (n >= 40) begin
      failures++;
      final_report();
    end
  endtask

  task automatic wr(input int r, input logic [7:0] v);
    bus(1'b1, idx[r], v);
    if (r < 4) ctl[r] = v & CTRL_MASK;
    else vs = v & VSEL_MASK;
  endtask

  task automatic rb(input int r);
    bus(1'b0, idx[r], 8'h00);
    check(rd, {24'h0, r < 4 ? ctl[r] : vs});
  endtask

  // model reaction to a change of one source; only the selected source acts
  task automatic upd(input logic [1:0] s, input logic [3:0] ol, oc, vl, vc);
    for (int i = 0; i < 4; i++) begin
      if (oc[i] && ctl[i][2:1] == s) ctl[i][0] = ol[i];
      if (vc[i] && ctl[i][6:5] == s) vs[4 + i] = vl[i];
    end
  endtask

  task automatic chk_out();
    logic [3:0] on, pd, hd;
    repeat (8) @(posedge REF_CLK_I);
    for (int i = 0; i < 4; i++) begin
      on[i] = ctl[i][0] & (~LOW_POWER_OFF_I | ctl[i][7]);
      pd[i] = ~on[i] & ~ctl[i][3];
      hd[i] = ctl[i][7];
    end
    check(32'(REG_ON_O), 32'(on));
    check(32'(REG_PULLDOWN_O), 32'(pd));
    check(32'(REG_SEQ_HANDLED_O), 32'(hd));
    check(32'(REG_VOLTAGE_CHOICE_O), 32'(vs[7:4]));
    check(32'(CONV_VOLTAGE_CHOICE_O), 32'({vs[2], vs[3], vs[0]}));
  endtask

  initial begin
    logic [7:0] v;
    logic       lv;
    {RSTN_I, HSEL_I, HWRITE_I, LOW_POWER_OFF_I, slow, HTRANS_I} = '0;
    {HADDR_I, HWDATA_I} = '0;
    HSIZE_I = 3'h2;
    pin_lvl = 3'h0;
    {SEQ_REG_ON_I, SEQ_REG_VSEL_I} = '0;
    lfsr_s = 32'h122A;
    failures = 0;
    n_tests = 0;
    foreach (ctl[i]) ctl[i] = CTRL_RESET;
    vs = VSEL_RESET;
    repeat (6) @(posedge REF_CLK_I);
    RSTN_I <= 1'b1;
    for (int r = 0; r < 5; r++) rb(r);
    // unmapped place: write ignored, reads zero
    bus(1'b1, 12'h030, 8'hFF);
    bus(1'b0, 12'h030, 8'h00);
    check(rd, 32'h0);
    for (int k = 0; k < 8; k++) begin
      v = rnd();
      LOW_POWER_OFF_I <= v[0];
      slow <= v[1];
      for (int r = 0; r < 4; r++) begin
        v = rnd();
        wr(r, {v[7], 2'(k + r + 1), v[4:3], 2'(k + r), v[0]});
      end
      v = rnd();
      wr(4, v);
      for (int r = 0; r < 5; r++) rb(r);
      chk_out();
      // each pin goes active then passive
      for (int p = 0; p < 6; p++) begin
        lv = ~p[0];
        pin_lvl[p / 2] <= lv;
        upd(2'(p / 2 + 1), {4{lv}}, 4'hF, {4{lv}}, 4'hF);
        chk_out();
      end
      // sequencer as source code zero
      v = rnd();
      upd(2'h0, v[3:0], v[3:0] ^ SEQ_REG_ON_I, v[7:4], v[7:4] ^ SEQ_REG_VSEL_I);
      SEQ_REG_ON_I <= v[3:0];
      SEQ_REG_VSEL_I <= v[7:4];
      chk_out();
      for (int r = 0; r < 5; r++) rb(r);
    end
    final_report();
  end
endmodule
